// File: adm_mux.sv
// Shared address/data pin multiplexer with flag-line takeover
// Operation
// - Flag mode needs control bit 20, port disabled
// - Pins 0-7 carry flags 8-15, pins 8-15 flags 0-7
// - 8-bit ALE phase: A15-8 low, A23-16 high
// - 8-bit data phase: D7-0 low, A7-0 high
// - 16-bit ALE phase: A7-0 low, A15-8 high
// - 16-bit data phase: D15-0 on all pins
// - Read, write, ALE strobes always driven
module adm_mux (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [adm_pkg::CTRL_W-1:0] system_control_reg,
	input wire logic port_enable,
	input wire logic port_width_setting,
	input wire logic req_valid,
	output logic req_ready,
	input wire adm_pkg::adm_req_t req,
	output logic rd_valid,
	output logic [adm_pkg::PIN_W-1:0] rd_data,
	input wire logic [adm_pkg::PIN_W-1:0] general_io_out,
	input wire logic [adm_pkg::PIN_W-1:0] general_io_oe_n,
	output logic [adm_pkg::PIN_W-1:0] general_io_lines,
	input wire logic [adm_pkg::PIN_W-1:0] shared_addr_data_pins_in,
	output logic [adm_pkg::PIN_W-1:0] shared_addr_data_pins_out,
	output logic [adm_pkg::PIN_W-1:0] shared_addr_data_pins_oe_n,
	output logic ale,
	output logic rd_n,
	output logic wr_n
);
	localparam int REQ_W = $bits(adm_pkg::adm_req_t);
	localparam int B = adm_pkg::BYTE_W;

	typedef enum logic [1:0] {
		ADM_IDLE,
		ADM_ADDR,
		ADM_STROBE,
		ADM_HOLD
	} adm_state_t;

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	logic [adm_pkg::PIN_W-1:0] pin_meta_reg;
	logic [adm_pkg::PIN_W-1:0] pin_sync_reg;
	always_ff @(posedge clk_sys) begin
		pin_meta_reg <= shared_addr_data_pins_in;
		pin_sync_reg <= pin_meta_reg;
	end

	// ****************************************
	// Request buffer
	// ****************************************
	logic buf_valid;
	logic buf_ready;
	logic [REQ_W-1:0] buf_bits;
	adm_skid #(.W(REQ_W)) u_skid (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(buf_bits)
	);
	adm_pkg::adm_req_t head;
	assign head = adm_pkg::adm_req_t'(buf_bits);

	// ****************************************
	// Mode decode
	// ****************************************
	logic flag_mode_reg;
	logic flag_mode_next;
	wire flag_req = system_control_reg[adm_pkg::FLAG_EN_BIT] && !port_enable;

	adm_state_t state_reg;
	adm_state_t state_next;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	adm_pkg::adm_req_t cur_reg;
	adm_pkg::adm_req_t cur_next;
	adm_pkg::adm_width_t width_reg;
	adm_pkg::adm_width_t width_next;

	// Mode switches only while idle so a cycle never loses its pins mid-way
	wire idle = (state_reg == ADM_IDLE);
	assign flag_mode_next = idle ? flag_req : flag_mode_reg;
	assign buf_ready = idle && !flag_mode_reg && port_enable && !flag_req;
	wire take = buf_valid && buf_ready;
	wire cnt_done = (cnt_reg == adm_pkg::CNT_ONE);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cur_next = cur_reg;
		width_next = width_reg;
		unique case (state_reg)
			ADM_IDLE: begin
				if (take) begin
					state_next = ADM_ADDR;
					cnt_next = adm_pkg::ALE_CNT;
					cur_next = head;
					width_next = port_width_setting ? adm_pkg::ADM_W16 : adm_pkg::ADM_W8;
				end
			end
			ADM_ADDR: begin
				cnt_next = cnt_reg - adm_pkg::CNT_ONE;
				if (cnt_done) begin
					state_next = ADM_STROBE;
					cnt_next = adm_pkg::STROBE_CNT;
				end
			end
			ADM_STROBE: begin
				cnt_next = cnt_reg - adm_pkg::CNT_ONE;
				if (cnt_done) begin
					state_next = ADM_HOLD;
					cnt_next = adm_pkg::HOLD_CNT;
				end
			end
			ADM_HOLD: begin
				cnt_next = cnt_reg - adm_pkg::CNT_ONE;
				if (cnt_done) begin
					state_next = ADM_IDLE;
					cnt_next = adm_pkg::CNT_ZERO;
				end
			end
		endcase
	end

	// ****************************************
	// Pin value selection
	// ****************************************
	wire is16 = (width_next == adm_pkg::ADM_W16);
	wire [adm_pkg::ADDR_W-1:0] a = cur_next.addr;
	wire [adm_pkg::PIN_W-1:0] d = cur_next.data;
	wire [adm_pkg::PIN_W-1:0] addr_word = is16 ? {a[15:8], a[7:0]}
		: {a[23:16], a[15:8]};
	wire [adm_pkg::PIN_W-1:0] data_word = is16 ? d
		: {a[7:0], d[7:0]};
	wire ph_addr = (state_next == ADM_ADDR);
	wire ph_data = (state_next == ADM_STROBE) || (state_next == ADM_HOLD);
	wire wr_cyc = cur_next.write;

	// Flag k sits on pin k+8 (mod 16), both directions
	logic [adm_pkg::PIN_W-1:0] flag_out_map;
	logic [adm_pkg::PIN_W-1:0] flag_oe_map;
	logic [adm_pkg::PIN_W-1:0] flag_in_map;
	for (genvar i = 0; i < adm_pkg::PIN_W; i++) begin : g_map
		localparam int J = (i + B) % adm_pkg::PIN_W;
		assign flag_out_map[i] = general_io_out[J];
		assign flag_oe_map[i] = general_io_oe_n[J];
		assign flag_in_map[J] = pin_sync_reg[i];
	end

	// Data byte 1 is an address byte in 8-bit mode, so it stays driven on reads
	wire [adm_pkg::PIN_W-1:0] rd_oe_n = is16 ? {adm_pkg::PIN_W{1'b1}}
		: {{B{1'b0}}, {B{1'b1}}};
	wire [adm_pkg::PIN_W-1:0] pins_out_next = flag_mode_next ? flag_out_map
		: ph_addr ? addr_word
		: ph_data ? data_word
		: '0;
	wire [adm_pkg::PIN_W-1:0] pins_oe_next = flag_mode_next ? flag_oe_map
		: ph_addr ? '0
		: (ph_data && wr_cyc) ? '0
		: (ph_data && !wr_cyc) ? rd_oe_n
		: '1;
	wire strobe_next = (state_next == ADM_STROBE);
	// The pins reach pin_sync_reg two edges late, so the read word is taken in hold
	wire sample = (state_reg == ADM_HOLD) && cnt_done && !cur_reg.write;
	wire [adm_pkg::PIN_W-1:0] rd_word = (width_reg == adm_pkg::ADM_W16) ? pin_sync_reg
		: {{B{1'b0}}, pin_sync_reg[7:0]};

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= ADM_IDLE;
			cnt_reg <= adm_pkg::CNT_ZERO;
			cur_reg <= '0;
			width_reg <= adm_pkg::ADM_W8;
			flag_mode_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cur_reg <= cur_next;
			width_reg <= width_next;
			flag_mode_reg <= flag_mode_next;
		end
	end

	// ****************************************
	// Pin and strobe outputs
	// ****************************************
	// Strobes are plain outputs with no enable, never floated
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shared_addr_data_pins_out <= '0;
			shared_addr_data_pins_oe_n <= '1;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else begin
			shared_addr_data_pins_out <= pins_out_next;
			shared_addr_data_pins_oe_n <= pins_oe_next;
			ale <= ph_addr;
			rd_n <= !(strobe_next && !wr_cyc);
			wr_n <= !(strobe_next && wr_cyc);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
			general_io_lines <= '0;
		end else begin
			rd_valid <= sample;
			if (sample) rd_data <= rd_word;
			general_io_lines <= flag_in_map;
		end
	end
endmodule : adm_mux

// File: adm_pkg.sv
// Package for the shared address/data pin multiplexer
package adm_pkg;
	// ****************************************
	// Widths and field positions
	// ****************************************
	localparam int PIN_W = 16;
	localparam int ADDR_W = 24;
	localparam int BYTE_W = 8;
	localparam int FLAG_EN_BIT = 20;
	localparam int CTRL_W = 32;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;
	// ****************************************
	// Timing counts, in clk_sys cycles
	// ****************************************
	localparam int ALE_CYCLES = 2;
	localparam int STROBE_CYCLES = 2;
	localparam int HOLD_CYCLES = 1;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] ALE_CNT = 2'h2;
	localparam logic [1:0] STROBE_CNT = 2'h2;
	localparam logic [1:0] HOLD_CNT = 2'h1;

	typedef enum logic {
		ADM_W8,
		ADM_W16
	} adm_width_t;

	// One transfer request from the core side
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [PIN_W-1:0] data;
	} adm_req_t;

	// Pin bundle driven out of the device
	typedef struct packed {
		logic [PIN_W-1:0] ad_out;
		logic [PIN_W-1:0] ad_oe_n;
		logic ale;
		logic rd_n;
		logic wr_n;
	} adm_pins_t;
endpackage : adm_pkg

// File: adm_skid.sv
// Two-entry buffer with valid and ready on both sides
module adm_skid #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic in_ready_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Ready comes from a flop so the request port sees no combinational path
	assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
	assign in_ready = in_ready_reg;
	assign out_valid = (count_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
			in_ready_reg <= 1'b1;
		end else begin
			if (push) wr_ptr_reg <= ~wr_ptr_reg;
			if (pop) rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_next;
			in_ready_reg <= (count_next != 2'h2);
		end
	end
endmodule : adm_skid

// File: adm_mux_checker.sv
// Port checks for the shared address/data pin multiplexer
module adm_mux_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [31:0] system_control_reg,
	input wire logic port_enable,
	input wire logic [15:0] general_io_out,
	input wire logic [15:0] general_io_oe_n,
	input wire logic [15:0] general_io_lines,
	input wire logic [15:0] shared_addr_data_pins_in,
	input wire logic [15:0] shared_addr_data_pins_out,
	input wire logic [15:0] shared_addr_data_pins_oe_n,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire logic fm = system_control_reg[20] && !port_enable;
	wire logic idle = !ale && rd_n && wr_n;
	AST_LAUNCH: assert property ($rose(ale) |-> $past(port_enable))
		else $error("transfer launched while port disabled");
	AST_NOT_FLAG: assert property ((!fm && idle)[*4] |-> shared_addr_data_pins_oe_n == 16'hffff)
		else $error("pins driven outside a transfer");
	AST_FLAG_PINS: assert property ((fm && idle && $stable(general_io_out))[*6] |->
		shared_addr_data_pins_out == {general_io_out[7:0], general_io_out[15:8]})
		else $error("flag outputs not swapped onto pins");
	AST_FLAG_IN: assert property ((fm && $stable(shared_addr_data_pins_in))[*5] |->
		general_io_lines == {shared_addr_data_pins_in[7:0], shared_addr_data_pins_in[15:8]})
		else $error("flag inputs not swapped from pins");
	AST_ALE_LEN: assert property ($rose(ale) |=> ale ##1 !ale)
		else $error("address strobe length wrong");
	AST_ALE_DRV: assert property (ale |-> shared_addr_data_pins_oe_n == 16'h0000)
		else $error("address phase not driven");
	AST_STROBE: assert property ($fell(ale) |-> (rd_n ^ wr_n)[*2] ##1 (rd_n && wr_n))
		else $error("data phase strobe wrong");
	AST_RD_REL: assert property (!rd_n |-> shared_addr_data_pins_oe_n[7:0] == 8'hff)
		else $error("low byte driven during read");
	AST_EXCL: assert property (!(ale && !(rd_n && wr_n)) && (rd_n || wr_n))
		else $error("strobes overlap");
	cover property ($fell(rd_n));
	cover property ($fell(wr_n));
	cover property (fm && idle);
endmodule : adm_mux_checker

bind adm_mux adm_mux_checker u_chk (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.system_control_reg(system_control_reg),
	.port_enable(port_enable),
	.general_io_out(general_io_out),
	.general_io_oe_n(general_io_oe_n),
	.general_io_lines(general_io_lines),
	.shared_addr_data_pins_in(shared_addr_data_pins_in),
	.shared_addr_data_pins_out(shared_addr_data_pins_out),
	.shared_addr_data_pins_oe_n(shared_addr_data_pins_oe_n),
	.ale(ale),
	.rd_n(rd_n),
	.wr_n(wr_n)
);

// File: adm_mem_model.sv
// External memory with address latch on the shared pins
module adm_mem_model (
	input wire logic clk_sys,
	input wire logic [15:0] shared_addr_data_pins_out,
	input wire logic [15:0] shared_addr_data_pins_oe_n,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [15:0] shared_addr_data_pins_in,
	output logic [15:0] lat,
	output logic [15:0] wdat
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Latch and answer
	// ****
	always_ff @(posedge clk_sys) begin
		if (ale) lat <= shared_addr_data_pins_in;
		if (!wr_n) wdat <= shared_addr_data_pins_in;
	end
	// Released bits go to the pull-up level; read answer is the inverted latch
	assign shared_addr_data_pins_in = (~shared_addr_data_pins_oe_n & shared_addr_data_pins_out)
		| (shared_addr_data_pins_oe_n & (rd_n ? 16'hffff : ~lat));
endmodule : adm_mem_model

// File: test_adm_mux.sv
// Self-checking bench for the pin multiplexer
module test_adm_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] system_control_reg;
	logic port_enable, port_width_setting, req_valid, req_ready, rd_valid, ale, rd_n, wr_n;
	adm_pkg::adm_req_t req;
	logic [15:0] rd_data, general_io_out, general_io_oe_n, general_io_lines, lat, wdat, got;
	logic [15:0] shared_addr_data_pins_in, shared_addr_data_pins_out, shared_addr_data_pins_oe_n;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int rd_seen = 0;
	always #25 clk_sys = ~clk_sys;
	adm_mux dut (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.system_control_reg(system_control_reg),
		.port_enable(port_enable),
		.port_width_setting(port_width_setting),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req(req),
		.rd_valid(rd_valid),
		.rd_data(rd_data),
		.general_io_out(general_io_out),
		.general_io_oe_n(general_io_oe_n),
		.general_io_lines(general_io_lines),
		.shared_addr_data_pins_in(shared_addr_data_pins_in),
		.shared_addr_data_pins_out(shared_addr_data_pins_out),
		.shared_addr_data_pins_oe_n(shared_addr_data_pins_oe_n),
		.ale(ale),
		.rd_n(rd_n),
		.wr_n(wr_n)
	);
	adm_mem_model mem (
		.clk_sys(clk_sys),
		.shared_addr_data_pins_out(shared_addr_data_pins_out),
		.shared_addr_data_pins_oe_n(shared_addr_data_pins_oe_n),
		.ale(ale),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.shared_addr_data_pins_in(shared_addr_data_pins_in),
		.lat(lat),
		.wdat(wdat)
	);
	// Read pulses are counted so a missing or doubled pulse shows up
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1) begin
			got <= rd_data;
			rd_seen <= rd_seen + 1;
		end
	end
	// ****
	// Helpers
	// ****
	task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
		n_compared++;
		if (got_v !== exp_v) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask : chk
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// Hang guard: the whole run needs under a hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic push(input logic wr, input logic [23:0] a, input logic [15:0] d, input logic w);
		do @(negedge clk_sys); while (req_ready !== 1'b1);
		@(posedge clk_sys);
		port_width_setting <= w;
		req_valid <= 1'b1;
		req <= {wr, a, d};
		@(posedge clk_sys);
		req_valid <= 1'b0;
	endtask : push
	task automatic settle;
		int n = 0;
		while (rd_n && wr_n && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		while (!(rd_n && wr_n) && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		repeat (2) @(negedge clk_sys);
		if (n == 40) err_count++;
	endtask : settle
	// ****
	// Scenarios
	// ****
	task automatic t_write(input logic w);
		push(1'b1, 24'hc3a512, 16'h5e71, w);
		settle();
		chk(lat, w ? 16'ha512 : 16'hc3a5);
		chk(wdat, w ? 16'h5e71 : 16'h1271);
	endtask : t_write
	task automatic t_read(input logic w);
		int seen0;
		seen0 = rd_seen;
		push(1'b0, 24'h9b4d2e, 16'h0000, w);
		settle();
		chk(16'(rd_seen - seen0), 16'h0001);
		chk(got, w ? 16'hb2d1 : 16'h00b2);
	endtask : t_read
	task automatic t_buffer;
		@(posedge clk_sys);
		port_enable <= 1'b0;
		push(1'b1, 24'h000001, 16'h1111, 1'b1);
		push(1'b1, 24'h000002, 16'h2222, 1'b1);
		@(negedge clk_sys);
		chk({15'h0000, req_ready}, 16'h0000);
		@(posedge clk_sys);
		port_enable <= 1'b1;
		settle();
		chk(wdat, 16'h1111);
		settle();
		chk(wdat, 16'h2222);
	endtask : t_buffer
	task automatic t_flags;
		@(posedge clk_sys);
		system_control_reg <= 32'h0010_0000;
		port_enable <= 1'b0;
		general_io_out <= 16'h5a3c;
		general_io_oe_n <= 16'h00ff;
		repeat (8) @(negedge clk_sys);
		chk(shared_addr_data_pins_oe_n, 16'hff00);
		chk(shared_addr_data_pins_out, 16'h3c5a);
		chk(general_io_lines, 16'h5aff);
		@(posedge clk_sys);
		port_enable <= 1'b1;
		repeat (8) @(negedge clk_sys);
		chk(shared_addr_data_pins_oe_n, 16'hffff);
	endtask : t_flags
	initial begin
		{system_control_reg, port_enable, port_width_setting, req_valid, req} = '0;
		general_io_out = 16'h0000;
		general_io_oe_n = 16'hffff;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		port_enable <= 1'b1;
		for (int w = 0; w < 2; w++) begin
			t_write(w[0]);
			t_read(w[0]);
		end
		t_buffer();
		t_flags();
		wrap_up();
	end
endmodule : test_adm_mux
